/* clock_manager_pkg.sv */
// Constants, register map and carrier types of the clock manager.
// Assumes one system clock of 200 MHz; every input but the asynchronous reset is synchronous to it.
package clock_manager_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int STOP_TIME_NS  = 2000;
  localparam int CW            = 12;
  // cycles without a source edge before the input counts as stopped
  localparam logic [CW-1:0] STOP_CYC = CW'(STOP_TIME_NS * 1000 / CLK_PERIOD_PS);
  localparam int LOCK_EDGES_DEF = 8;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SHIFT  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK   = 4'hC;

  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_DIV_LSB  = 8;
  localparam int CTRL_DV_LSB   = 16;
  localparam int CTRL_HF_BIT   = 24;
  localparam int CTRL_FB_BIT   = 25;
  localparam int CTRL_FX_BIT   = 26;
  localparam int CTRL_FINE_BIT = 27;
  localparam int CTRL_VAR_BIT  = 28;
  localparam int CTRL_HALF_BIT = 29;
  localparam int STAT_LIVE_LSB = 8;
  localparam int STAT_LOCK_BIT = 16;

  localparam logic [5:0] MULT_RST = 6'h04;
  localparam logic [5:0] DIV_RST  = 6'h01;
  localparam logic [5:0] DV_RST   = 6'h04;

  localparam int STAT_OVF     = 0;
  localparam int STAT_IN_STOP = 1;
  localparam int STAT_FX_STOP = 2;

  localparam logic signed [7:0] SHIFT_MAX = 8'sh7F;
  localparam logic signed [7:0] SHIFT_MIN = 8'sh81;

  typedef struct packed {
    logic [5:0] mult;
    logic [5:0] div;
    logic [5:0] dv;
    logic       hf;
    logic       fb_used;
    logic       fx_used;
    logic       fine;
    logic       var_mode;
    logic       input_halving_option;
  } ctrl_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic out_phase_zero;
    logic out_phase_quarter;
    logic out_phase_half;
    logic out_phase_three_quarter;
    logic out_double_rate;
    logic out_double_rate_inverted;
    logic out_divided;
    logic out_synthesised;
    logic out_synthesised_inverted;
  } clk_out_t;

endpackage

/* clock_manager.sv */
// Clock manager: de-skew, coarse and fine phase, doubling, division, synthesis.
// Assumes source, feedback and step-clock inputs are synchronous to clk_sys_i
// and that the source period is at least 4 system cycles.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module clock_manager #(
  parameter int unsigned LOCK_EDGES         = clock_manager_pkg::LOCK_EDGES_DEF,
  parameter bit          HOLD_CONFIG_ON_LOCK = 1'b1
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        source_clock_i,
  input  wire logic                        feedback_clock_i,
  input  wire logic                        shift_step_clock_i,
  input  wire logic                        shift_step_enable_i,
  input  wire logic                        shift_step_direction_i,
  input  wire clock_manager_pkg::reg_req_t reg_req_i,
  output logic [31:0]                      reg_rdata_o,
  output clock_manager_pkg::clk_out_t      clocks_o,
  output logic                             locked_o,
  output logic [7:0]                       status_o,
  output logic                             config_hold_o,
  output logic                             irq_o
);
  import clock_manager_pkg::*;

  if (LOCK_EDGES < 1 || LOCK_EDGES > 15) begin : g_bad_lock
    $error("LOCK_EDGES must lie in 1..15");
  end

  // all state in one struct, so reset and next-state logic cannot drift apart
  typedef struct packed {
    ctrl_t             ctrl;
    logic              src_q;
    logic              fb_q;
    logic              ps_q;
    logic              half_tog;
    logic              aligned;
    logic              lock;
    logic              ovf;
    logic              fx;
    logic [CW-1:0]     cnt;
    logic [CW-1:0]     per;
    logic [CW-1:0]     tap;
    logic [CW-1:0]     ph;
    logic [CW-1:0]     fx_idle;
    logic [3:0]        stable;
    logic signed [7:0] shift;
    logic [6:0]        dcnt;
    logic [17:0]       acc;
    logic [2:0]        live_q;
    logic [2:0]        sticky;
    logic [2:0]        mask;
    logic [31:0]       rdata;
    clk_out_t          outs;
  } state_t;

  // s is the registered state, next_s its next-state copy
  state_t             s;
  state_t             next_s;
  logic               src_rise;
  logic               edge_q;
  logic               fb_rise;
  logic               step;
  logic               restart;
  logic               in_stop;
  logic               fx_stop;
  logic               wr_ctrl;
  logic               wr_shift;
  logic [CW-1:0]      ph_n;
  logic [CW-1:0]      half;
  logic [CW-1:0]      q1;
  logic [CW-1:0]      q3;
  logic [CW-1:0]      tgt;
  logic signed [20:0] prod;
  logic signed [12:0] off;
  logic [12:0]        tgt13;
  logic [17:0]        acc2;
  logic [17:0]        thr;
  logic [2:0]         live;
  logic [31:0]        rv;
  logic [5:0]         w_mult;
  logic [5:0]         w_div;
  logic [5:0]         w_dv;

  function automatic logic in_range(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // halves 3..16, then even halves 18..32 only
  function automatic logic legal_dv(input logic [5:0] v);
    return in_range(v, 6'h03, 6'h10) || (!v[0] && in_range(v, 6'h12, 6'h20));
  endfunction

  // edge detection and derived phase points
  // quarter points round down, so an odd period gives a slightly short quarter
  assign src_rise = source_clock_i & ~s.src_q;
  assign edge_q   = src_rise & (~s.ctrl.input_halving_option | s.half_tog);
  assign fb_rise  = feedback_clock_i & ~s.fb_q;
  assign step     = shift_step_clock_i & ~s.ps_q & shift_step_enable_i
                    & s.ctrl.fine & s.ctrl.var_mode;
  assign in_stop  = (s.cnt == STOP_CYC);
  assign fx_stop  = s.ctrl.fx_used && (s.fx_idle == STOP_CYC);
  assign restart  = (s.cnt == s.tap) && !in_stop;
  assign half     = s.per >> 1;
  assign q1       = s.per >> 2;
  assign q3       = half + q1;
  assign ph_n     = (restart || s.ph >= s.per - 12'h001) ? 12'h000 : s.ph + 12'h001;
  assign live     = {fx_stop, in_stop, s.ovf};

  // fine shift target: shift/256 of the period, wrapped into 0..per-1
  // wrapping keeps the delay line target positive for negative shifts
  assign prod  = $signed({1'b0, s.per}) * $signed(s.shift);
  assign off   = $signed(prod[20:8]);
  assign tgt13 = off[12] ? ({1'b0, s.per} + off) : off;
  assign tgt   = s.ctrl.fine ? tgt13[CW-1:0] : 12'h000;

  // synthesiser accumulator: 2M half-cycles per D source periods
  assign thr  = 18'(s.ctrl.div) * 18'(s.per);
  assign acc2 = s.acc + 18'({s.ctrl.mult, 1'b0});

  // register decode: exact address match only, no byte lanes
  assign wr_ctrl  = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL);
  assign wr_shift = reg_req_i.wr && (reg_req_i.addr == ADDR_SHIFT);
  assign w_mult   = reg_req_i.wdata[CTRL_MULT_LSB +: 6];
  assign w_div    = reg_req_i.wdata[CTRL_DIV_LSB +: 6];
  assign w_dv     = reg_req_i.wdata[CTRL_DV_LSB +: 6];

  always_comb begin : next_state
    next_s          = s;
    rv              = 32'h0000_0000;
    next_s.src_q    = source_clock_i;
    next_s.fb_q     = feedback_clock_i;
    next_s.ps_q     = shift_step_clock_i;
    next_s.live_q   = live;
    if (src_rise) begin
      next_s.half_tog = ~s.half_tog;
    end

    // period measurement and stop watchdog
    // the watchdog saturates so a stopped source cannot wrap back to running
    if (edge_q) begin
      next_s.cnt = 12'h000;
      next_s.per = s.cnt + 12'h001;
    end else if (!in_stop) begin
      next_s.cnt = s.cnt + 12'h001;
    end

    // delay line: step one tap per feedback edge toward the target
    // one tap per edge is slow to settle but can never overshoot the target
    if (!s.ctrl.fb_used) begin
      next_s.tap = 12'h000;
    end else if (fb_rise && !in_stop) begin
      if (s.cnt < tgt) begin
        next_s.tap = (s.tap >= s.per - 12'h001) ? 12'h000 : s.tap + 12'h001;
      end else if (s.cnt > tgt) begin
        next_s.tap = (s.tap == 12'h000) ? s.per - 12'h001 : s.tap - 12'h001;
      end
    end
    if (fb_rise) begin
      next_s.aligned = (s.cnt == tgt);
    end else if (edge_q) begin
      next_s.aligned = 1'b0;
    end

    // lock: period stable, and delay line aligned when feedback is used, for several edges
    // a control write restarts the count, as any output may change with it
    if (edge_q) begin
      if (s.per == s.cnt + 12'h001 && (!s.ctrl.fb_used || s.aligned)) begin
        if (s.stable != 4'(LOCK_EDGES)) begin
          next_s.stable = s.stable + 4'h1;
        end
      end else begin
        next_s.stable = 4'h0;
      end
    end
    if (in_stop || wr_ctrl) begin
      next_s.stable = 4'h0;
    end
    next_s.lock = (s.stable == 4'(LOCK_EDGES)) && !in_stop && !fx_stop;

    // phase counter restarts on the delayed source edge
    next_s.ph = ph_n;
    next_s.outs.out_phase_zero          = !in_stop && (ph_n < half);
    next_s.outs.out_phase_half          = !in_stop && (ph_n >= half);
    next_s.outs.out_phase_quarter       = !in_stop && !s.ctrl.hf && (ph_n >= q1) && (ph_n < q3);
    next_s.outs.out_phase_three_quarter = !in_stop && !s.ctrl.hf && !((ph_n >= q1) && (ph_n < q3));
    next_s.outs.out_double_rate          = !in_stop && !s.ctrl.hf
                                           && ((ph_n < q1) || (ph_n >= half && ph_n < q3));
    next_s.outs.out_double_rate_inverted = !in_stop && !s.ctrl.hf
                                           && !((ph_n < q1) || (ph_n >= half && ph_n < q3));

    // divider counts quarter ticks; 2n quarters per period keeps 50/50
    // it re-aligns to the zero output on each restart until lock, then runs
    // free: clearing it every period would cap the ratio at one
    if (wr_ctrl || (restart && !s.lock)) begin
      next_s.dcnt = 7'h00;
    end else if (ph_n != s.ph && (ph_n == q1 || ph_n == half || ph_n == q3 || ph_n == 12'h000)) begin
      next_s.dcnt = (s.dcnt >= {s.ctrl.dv, 1'b0} - 7'h01) ? 7'h00 : s.dcnt + 7'h01;
    end
    next_s.outs.out_divided = !in_stop && (next_s.dcnt < {1'b0, s.ctrl.dv});

    // synthesiser toggles each half of its own period; stalls with the source
    // its phase runs free of the zero output; only its rate follows the source
    if (!s.ctrl.fx_used || in_stop) begin
      next_s.acc = 18'h0_0000;
    end else if (acc2 >= thr) begin
      next_s.acc = acc2 - thr;
      next_s.fx  = ~s.fx;
    end else begin
      next_s.acc = acc2;
    end
    if (next_s.fx != s.fx || !s.ctrl.fx_used) begin
      next_s.fx_idle = 12'h000;
    end else if (s.fx_idle != STOP_CYC) begin
      next_s.fx_idle = s.fx_idle + 12'h001;
    end
    next_s.outs.out_synthesised          = s.fx;
    next_s.outs.out_synthesised_inverted = ~s.fx;

    // variable fine shift; saturation flags overflow instead of wrapping
    // a written -128 lies past the lower end, so it saturates there as well
    if (wr_shift) begin
      next_s.shift = $signed(reg_req_i.wdata[7:0]);
      next_s.ovf   = 1'b0;
    end
    if (step) begin
      if (shift_step_direction_i) begin
        if (s.shift >= SHIFT_MAX) begin
          next_s.ovf = 1'b1;
        end else if (!wr_shift) begin
          next_s.shift = s.shift + 8'sh01;
        end
      end else begin
        if (s.shift <= SHIFT_MIN) begin
          next_s.ovf = 1'b1;
        end else if (!wr_shift) begin
          next_s.shift = s.shift - 8'sh01;
        end
      end
    end

    // control writes; illegal field values leave that field unchanged
    if (wr_ctrl) begin
      if (in_range(w_mult, 6'h02, 6'h20)) begin
        next_s.ctrl.mult = w_mult;
      end
      if (in_range(w_div, 6'h01, 6'h20)) begin
        next_s.ctrl.div = w_div;
      end
      if (legal_dv(w_dv)) begin
        next_s.ctrl.dv = w_dv;
      end
      next_s.ctrl.hf                   = reg_req_i.wdata[CTRL_HF_BIT];
      next_s.ctrl.fb_used              = reg_req_i.wdata[CTRL_FB_BIT];
      next_s.ctrl.fx_used              = reg_req_i.wdata[CTRL_FX_BIT];
      next_s.ctrl.fine                 = reg_req_i.wdata[CTRL_FINE_BIT];
      next_s.ctrl.var_mode             = reg_req_i.wdata[CTRL_VAR_BIT];
      next_s.ctrl.input_halving_option = reg_req_i.wdata[CTRL_HALF_BIT];
    end
    if (reg_req_i.wr && reg_req_i.addr == ADDR_MASK) begin
      next_s.mask = reg_req_i.wdata[2:0];
    end

    // sticky events: a new event wins over a same-cycle write-one-to-clear
    // events are rises of the registered live view, one per rise
    if (reg_req_i.wr && reg_req_i.addr == ADDR_STATUS) begin
      next_s.sticky = s.sticky & ~reg_req_i.wdata[2:0];
    end
    next_s.sticky = next_s.sticky | (live & ~s.live_q);

    // read data valid only in the cycle after the strobe
    // unmapped addresses read as zero so software can probe safely
    case (reg_req_i.addr)
      ADDR_CTRL: begin
        rv[CTRL_MULT_LSB +: 6] = s.ctrl.mult;
        rv[CTRL_DIV_LSB +: 6]  = s.ctrl.div;
        rv[CTRL_DV_LSB +: 6]   = s.ctrl.dv;
        rv[CTRL_HF_BIT]        = s.ctrl.hf;
        rv[CTRL_FB_BIT]        = s.ctrl.fb_used;
        rv[CTRL_FX_BIT]        = s.ctrl.fx_used;
        rv[CTRL_FINE_BIT]      = s.ctrl.fine;
        rv[CTRL_VAR_BIT]       = s.ctrl.var_mode;
        rv[CTRL_HALF_BIT]      = s.ctrl.input_halving_option;
      end
      ADDR_SHIFT:  rv[7:0] = s.shift;
      ADDR_STATUS: begin
        rv[2:0]                 = s.sticky;
        rv[STAT_LIVE_LSB +: 3]  = s.live_q;
        rv[STAT_LOCK_BIT]       = s.lock;
      end
      ADDR_MASK:   rv[2:0] = s.mask;
      default:     rv = 32'h0000_0000;
    endcase
    next_s.rdata = reg_req_i.rd ? rv : 32'h0000_0000;
  end

  // every register, delay line and shift value returns to its start on reset
  // control fields restart at multiply four over one, mode bits off
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin : state_reg
    if (!arst_n_i) begin
      s           <= '0;
      s.ctrl.mult <= MULT_RST;
      s.ctrl.div  <= DIV_RST;
      s.ctrl.dv   <= DV_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops; only hold and interrupt are gated
  assign clocks_o      = s.outs;
  assign locked_o      = s.lock;
  assign status_o      = {5'h00, s.live_q};
  assign reg_rdata_o   = s.rdata;
  assign config_hold_o = HOLD_CONFIG_ON_LOCK && !s.lock;
  assign irq_o         = |(s.sticky & s.mask);

  // checks next to the logic they guard
  // reset disables them: the first cycles after release still show reset values
  AST_CFG_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $fell(config_hold_o) |-> locked_o) else $error("config released without lock");
  AST_LOCK_CAUSE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(locked_o) |-> $past(s.stable) == 4'(LOCK_EDGES) && !status_o[STAT_IN_STOP])
    else $error("lock rose without stable edges");
  AST_LOCK_DROP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    in_stop |=> !locked_o) else $error("lock held while input stopped");
  AST_STATUS_SPARE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    status_o[7:3] == 5'h00) else $error("spare status bits not zero");
  AST_STATUS_STOP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    in_stop |=> status_o[STAT_IN_STOP]) else $error("input stop not reported");
  AST_INV_SYNTH: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    1'b1 |=> clocks_o.out_synthesised_inverted != clocks_o.out_synthesised)
    else $error("inverted synthesised output not complementary");
  AST_INV_DOUBLE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !s.ctrl.hf && !in_stop |=> clocks_o.out_double_rate_inverted != clocks_o.out_double_rate)
    else $error("inverted double-rate output not complementary");
  AST_HF_OFF: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s.ctrl.hf |=> !clocks_o.out_double_rate && !clocks_o.out_double_rate_inverted
    && !clocks_o.out_phase_quarter && !clocks_o.out_phase_three_quarter)
    else $error("high-frequency mode left an output running");
  AST_ALIGN: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    restart && s.per >= 12'h004 |=> clocks_o.out_phase_zero && !clocks_o.out_phase_quarter
    && (s.ctrl.hf || clocks_o.out_double_rate)) else $error("outputs not aligned to zero phase");
  AST_STEP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    step && shift_step_direction_i && !wr_shift && s.shift != SHIFT_MAX
    |=> s.shift == $past(s.shift) + 8'sh01) else $error("shift did not step up");
  AST_OVERFLOW: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    step && !shift_step_direction_i && !wr_shift && s.shift == SHIFT_MIN
    |=> $stable(s.shift) ##1 status_o[STAT_OVF]) else $error("overflow not flagged");
  AST_TAP_MOVE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    fb_rise && s.ctrl.fb_used && !in_stop && s.cnt != tgt |=> s.tap != $past(s.tap))
    else $error("delay line did not move");
  AST_DIV_RANGE: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    legal_dv(s.ctrl.dv) && s.dcnt < {s.ctrl.dv, 1'b0}) else $error("divider out of range");
  AST_OVF_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_shift && !step |=> !s.ovf) else $error("shift write left overflow set");
  AST_STICKY_SET: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    live[STAT_OVF] && !s.live_q[STAT_OVF] |=> s.sticky[STAT_OVF]) else $error("overflow event not held");
  AST_STOP_OUTS: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    in_stop |=> !clocks_o.out_phase_zero && !clocks_o.out_divided) else $error("outputs ran while input stopped");

  COV_LOCK: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(locked_o));
  COV_OVF:  cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(status_o[STAT_OVF]));
  COV_FX:   cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(clocks_o.out_synthesised) && locked_o);
  COV_IRQ:  cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) $rose(irq_o));
  COV_STOP: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(status_o[STAT_IN_STOP]));

endmodule // clock_manager

`default_nettype wire

/* clock_fabric_model.sv */
// Far-side fabric model: routes the zero-phase output back as feedback and
// drives the fine-shift step port. Assumes go_i is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none

module clock_fabric_model #(
  parameter int FB_DELAY = 2
) (
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic zero_i,
  input  wire logic go_i,
  input  wire logic dir_i,
  output logic      fb_o,
  output logic      step_clk_o,
  output logic      step_en_o,
  output logic      step_dir_o
);
  logic [FB_DELAY-1:0] dly;
  logic [1:0]          ph;

  assign fb_o = dly[FB_DELAY-1];

  // feedback delay line plus a step pulse held high two samples, low after
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly        <= '0;
      ph         <= 2'h0;
      step_clk_o <= 1'b0;
      step_en_o  <= 1'b0;
      step_dir_o <= 1'b0;
    end else begin
      dly <= {dly[FB_DELAY-2:0], zero_i};
      if (go_i) begin
        step_clk_o <= 1'b1;
        step_en_o  <= 1'b1;
        step_dir_o <= dir_i;
        ph         <= 2'h2;
      end else if (ph == 2'h1) begin
        step_clk_o <= 1'b0;
        step_en_o  <= 1'b0;
        step_dir_o <= ~step_dir_o; // released: direction flips to the opposite of the last step
        ph         <= 2'h0;
      end else if (ph != 2'h0) begin
        ph <= ph - 2'h1;
      end
    end
  end
endmodule // clock_fabric_model

`default_nettype wire

/* clock_manager_deskew_synth_bench.sv */
// Self-checking bench of the clock manager with a fabric model at its far side.
// Assumes a source period of 8 system cycles and a short lock count.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module clock_manager_deskew_synth_bench;
  import clock_manager_pkg::*;
  localparam int PER   = 8;
  localparam int LIMIT = 20000; // all tests need about 1200 cycles
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        src       = 1'b0;
  logic        src_run   = 1'b0;
  logic        go        = 1'b0;
  logic        gdir      = 1'b0;
  logic        fb, sclk, sen, sdir, locked, hold, irq;
  reg_req_t    req       = '0;
  logic [31:0] rdata, rd_val;
  logic [31:0] seed      = 32'hB8C49BC4;
  logic [7:0]  status, exp_sh, v;
  clk_out_t    clks;
  int          src_cnt = 0, err_total = 0, checks_done = 0, cyc = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  clock_manager #(.LOCK_EDGES(2), .HOLD_CONFIG_ON_LOCK(1'b1)) dut_u (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .source_clock_i(src), .feedback_clock_i(fb),
    .shift_step_clock_i(sclk), .shift_step_enable_i(sen), .shift_step_direction_i(sdir),
    .reg_req_i(req), .reg_rdata_o(rdata), .clocks_o(clks), .locked_o(locked),
    .status_o(status), .config_hold_o(hold), .irq_o(irq));

  clock_fabric_model #(.FB_DELAY(2)) model_u (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .zero_i(clks.out_phase_zero), .go_i(go),
    .dir_i(gdir), .fb_o(fb), .step_clk_o(sclk), .step_en_o(sen), .step_dir_o(sdir));

  // source clock, half high half low; it stands low while stopped
  always @(posedge clk_sys_i) begin
    src_cnt <= src_run ? (src_cnt + 1) % PER : 0;
    src     <= src_run && (src_cnt < PER / 2);
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      $display("[ERR] timeout exp done got hang");
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected shift after one step, clamped at plus or minus 127
  function automatic logic [7:0] nxt(logic [7:0] s, logic d);
    if (d && $signed(s) < 127) return s + 8'h01;
    if (!d && $signed(s) > -127) return s - 8'h01;
    return s;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic step(input logic d);
    @(posedge clk_sys_i);
    go   <= 1'b1;
    gdir <= d;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wait_lock();
    for (int i = 0; i < 3000 && locked !== 1'b1; i++) @(posedge clk_sys_i);
    #1;
  endtask

  // counts edges and high samples over eight source periods after a zero-phase rise
  task automatic count_edges();
    clk_out_t p;
    int n2, ndv, nfx, hdv, hfx, bad, tz, tq;
    {n2, ndv, nfx, hdv, hfx, bad, tz, tq} = '0;
    for (int i = 0; i < 40 && !(p.out_phase_zero === 1'b0 && clks.out_phase_zero === 1'b1); i++) begin
      p = clks;
      @(posedge clk_sys_i);
      #1;
    end
    for (int i = 1; i <= 64; i++) begin
      p = clks;
      @(posedge clk_sys_i);
      #1;
      n2  += int'(!p.out_double_rate && clks.out_double_rate);
      ndv += int'(!p.out_divided && clks.out_divided);
      nfx += int'(!p.out_synthesised && clks.out_synthesised);
      hdv += int'(clks.out_divided);
      hfx += int'(clks.out_synthesised);
      bad += int'(clks.out_phase_half !== ~clks.out_phase_zero);
      bad += int'(clks.out_double_rate_inverted !== ~clks.out_double_rate);
      bad += int'(clks.out_phase_three_quarter !== ~clks.out_phase_quarter);
      bad += int'(clks.out_synthesised_inverted !== ~clks.out_synthesised);
      if (!p.out_phase_zero && clks.out_phase_zero) tz = i;
      if (!p.out_phase_quarter && clks.out_phase_quarter) tq = i;
    end
    `CHK("double_rises", 16, n2)
    `CHK("divided_rises", 4, ndv)
    `CHK("synth_rises", 32, nfx)
    `CHK("duty_div_synth", 64, hdv + hfx)
    `CHK("inverse_pairs", 0, bad)
    `CHK("quarter_spacing", PER / 4, (tq - tz + PER) % PER)
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    #1;
    `CHK("locked", 1'b0, locked)
    `CHK("hold", 1'b1, hold)
    `CHK("status", 8'h00, status)
    rd(ADDR_CTRL);
    `CHK("ctrl", 32'h00040104, rd_val)
    rd(4'h2);
    `CHK("unmapped", 32'h0, rd_val)
    $display("test reset done");
    src_run <= 1'b1;
    wr(ADDR_CTRL, 32'h1E040104);
    wait_lock();
    `CHK("locked", 1'b1, locked)
    `CHK("hold", 1'b0, hold)
    rd(ADDR_STATUS);
    `CHK("lock_bit", 1'b1, rd_val[STAT_LOCK_BIT])
    count_edges();
    wr(ADDR_CTRL, 32'h1F040104);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("hf_quarters", 2'b00, {clks.out_phase_quarter, clks.out_phase_three_quarter})
    `CHK("hf_double", 2'b00, {clks.out_double_rate, clks.out_double_rate_inverted})
    $display("test lock and outputs done");
    exp_sh = 8'h00;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      step(seed[0]);
      exp_sh = nxt(exp_sh, seed[0]);
      rd(ADDR_SHIFT);
      `CHK("shift_step", exp_sh, rd_val[7:0])
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v = (seed[7:0] == 8'h80) ? 8'h81 : seed[7:0];
      wr(ADDR_SHIFT, {24'h0, v});
      rd(ADDR_SHIFT);
      `CHK("shift_write", v, rd_val[7:0])
    end
    $display("test stepping done");
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_SHIFT, 32'h7E);
    step(1'b1);
    step(1'b1);
    `CHK("ovf_up", 1'b1, status[STAT_OVF])
    `CHK("irq_masked", 1'b0, irq)
    rd(ADDR_SHIFT);
    `CHK("shift_top", 8'h7F, rd_val[7:0])
    wr(ADDR_MASK, 32'h1);
    `CHK("irq_on", 1'b1, irq)
    wr(ADDR_STATUS, 32'h1);
    `CHK("irq_clr", 1'b0, irq)
    wr(ADDR_SHIFT, 32'h82);
    @(posedge clk_sys_i);
    #1;
    `CHK("ovf_clr", 1'b0, status[STAT_OVF])
    step(1'b0);
    step(1'b0);
    `CHK("ovf_down", 1'b1, status[STAT_OVF])
    `CHK("irq_again", 1'b1, irq)
    rd(ADDR_SHIFT);
    `CHK("shift_bottom", 8'h81, rd_val[7:0])
    $display("test overflow done");
    src_run <= 1'b0;
    repeat (820) @(posedge clk_sys_i);
    #1;
    `CHK("in_stop", 1'b1, status[STAT_IN_STOP])
    `CHK("fx_stop", 1'b1, status[STAT_FX_STOP])
    `CHK("spare_bits", 5'h00, status[7:3])
    `CHK("locked_stop", 1'b0, locked)
    `CHK("zero_stop", 1'b0, clks.out_phase_zero)
    src_run <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    #1;
    `CHK("in_run", 1'b0, status[STAT_IN_STOP])
    $display("test source stop done");
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("rst_locked", 1'b0, locked)
    `CHK("rst_status", 8'h00, status)
    `CHK("rst_clocks", 9'h000, clks)
    `CHK("rst_irq", 1'b0, irq)
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(ADDR_SHIFT);
    `CHK("rst_shift", 8'h00, rd_val[7:0])
    $display("test reset in mid-run done");
    give_verdict();
  end
endmodule // clock_manager_deskew_synth_bench

`default_nettype wire
